// ==== verilog/ipfs_pkg.sv ====
package ipfs_pkg;

    // Four phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_ONE = 4'h1,
        PH_TWO = 4'h2,
        PH_THREE = 4'h4,
        PH_FOUR = 4'h8
    } ipfs_phase_t;

    // Program counter
    localparam logic [20:0] PC_RESET = 21'h0_0000;
    localparam logic [20:0] PC_STEP = 21'h0_0002;
    localparam logic [20:0] VEC_HIGH = 21'h0_0008;
    localparam logic [20:0] VEC_LOW = 21'h0_0018;

    // Opcode patterns
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [15:0] OP_TBLRD = 16'h0008;
    localparam logic [14:0] OP_INTERRUPT_RETURN_INSTR = 15'h0008;
    localparam logic [14:0] OP_RETURN = 15'h0009;
    localparam logic [11:0] OP_MOVLB = 12'h010;
    localparam logic [5:0] OP_ADD_WORKING_TO_FILE_INSTR = 6'h09;
    localparam logic [7:0] OP_RETURN_WITH_LITERAL_INSTR = 8'h0C;
    localparam logic [7:0] OP_MOVLW = 8'h0E;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [7:0] OP_GOTO = 8'hEF;
    localparam logic [4:0] OP_BRA = 5'h1A;
    localparam logic [3:0] OP_SECOND = 4'hF;

    // Data memory map
    localparam logic [7:0] PCL_FILE = 8'hF9;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;

    // Register port offsets
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_WORKING = 3'h1;
    localparam logic [2:0] REG_BANK = 3'h2;
    localparam logic [2:0] REG_TLATCH = 3'h3;
    localparam logic [2:0] REG_TPTR_LOW = 3'h4;
    localparam logic [2:0] REG_TPTR_HIGH = 3'h5;
    localparam logic [2:0] REG_TPTR_UPPER = 3'h6;

    // Reset values
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [3:0] BSR_RESET = 4'h0;
    localparam logic [7:0] SHADOW_W_RESET = 8'h00;
    localparam logic [4:0] SHADOW_STATUS_RESET = 5'h00;
    localparam logic [3:0] SHADOW_BSR_RESET = 4'h0;
    localparam logic [20:0] TPTR_RESET = 21'h0_0000;
    localparam logic [7:0] TLATCH_RESET = 8'h00;

endpackage : ipfs_pkg

// ==== verilog/ipfs_phase_gen.sv ====
module ipfs_phase_gen
    import ipfs_pkg::*;
(
    // Clock and control
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Current phase
    output ipfs_phase_t phase
);

    // RULE_09 - divide by four
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase <= PH_ONE;
        end else if (clk_en) begin
            case (phase)
                PH_ONE: phase <= PH_TWO;
                PH_TWO: phase <= PH_THREE;
                PH_THREE: phase <= PH_FOUR;
                PH_FOUR: phase <= PH_ONE;
                default: phase <= PH_ONE;
            endcase
        end
    end

endmodule : ipfs_phase_gen

// ==== verilog/ipfs_core.sv ====
// How it works
// RULE_01 - One hidden shadow copy of status, working, bank
// RULE_02 - Interrupt vectoring saves all three into shadow
// RULE_03 - Fast interrupt return restores from shadow
// RULE_04 - High interrupt overwrites low interrupt's shadow
// RULE_05 - Fast call saves, fast return restores
// RULE_06 - Add to counter low advances by working
// RULE_07 - Literal return loads working, returns
// RULE_08 - Table read moves one byte to latch
// RULE_09 - Clock divided into four phases
// RULE_10 - Counter steps in one, fetch latched four
// RULE_11 - Fetch overlaps execute; jumps take two cycles
// RULE_12 - Operand read phase two, write phase four
// RULE_13 - Byte addressed, instructions on even addresses
// RULE_14 - Counter steps by two, bit zero clear
// RULE_15 - Absolute target fills counter bits 20:1
// RULE_16 - Branch offset counts words, doubled
// RULE_17 - Lone second word executes as no-op
// RULE_18 - Shadow cleared at reset
module ipfs_core
    import ipfs_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Program memory fetch
    output logic [20:0] prog_addr,
    input wire logic [15:0] prog_data,
    // Table read port
    output logic [20:0] table_addr,
    output logic table_rd,
    input wire logic [7:0] table_data,
    // Data memory
    output logic [11:0] data_addr,
    output logic data_rd,
    input wire logic [7:0] data_rdata,
    output logic data_wr,
    output logic [7:0] data_wdata,
    // Interrupt logic
    input wire logic irq_req,
    input wire logic irq_high,
    output logic irq_ack,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Phase indication
    output ipfs_phase_t phase
);

    function automatic logic [11:0] access_addr(
        input logic a_bit,
        input logic [7:0] f,
        input logic [3:0] bank
    );
        logic [3:0] hi;
        hi = (f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
        if (a_bit) begin
            hi = bank;
        end
        return {hi, f};
    endfunction : access_addr

    function automatic logic [20:0] bra_target(
        input logic [20:0] pc_now,
        input logic [10:0] words
    );
        logic [20:0] off;
        off = {{9{words[10]}}, words, 1'b0};
        return pc_now - PC_STEP + off;
    endfunction : bra_target

    function automatic logic [4:0] add_flags(
        input logic [7:0] x,
        input logic [7:0] y
    );
        logic [8:0] s;
        logic [4:0] fl;
        logic [4:0] lo;
        s = {1'b0, x} + {1'b0, y};
        lo = {1'b0, x[3:0]} + {1'b0, y[3:0]};
        fl = 5'h00;
        fl[ST_C] = s[8];
        fl[ST_DC] = lo[4];
        fl[ST_Z] = (s[7:0] == 8'h00);
        fl[ST_OV] = (x[7] == y[7]) && (s[7] != x[7]);
        fl[ST_N] = s[7];
        return fl;
    endfunction : add_flags

    // Core state
    logic [20:0] pc;
    logic [15:0] ir;
    logic ir_valid;
    logic [20:0] ret_addr;
    logic [7:0] working_register;
    logic [4:0] status;
    logic [3:0] bank_select_register;
    logic [7:0] shadow_w;
    logic [4:0] shadow_status;
    logic [3:0] shadow_bsr;
    logic [20:0] table_pointer;
    logic [7:0] table_latch;
    logic [7:0] result;
    logic [4:0] result_flags;

    // RULE_09 - four phase divider
    ipfs_phase_gen u_phase (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .phase(phase)
    );

    wire phase_one = (phase == PH_ONE);
    wire phase_two = (phase == PH_TWO);
    wire phase_three = (phase == PH_THREE);
    wire phase_four = (phase == PH_FOUR);

    // RULE_17 - lone second word ignored
    wire ir_live = ir_valid && (ir[15:12] != OP_SECOND);

    wire op_tblrd = ir_live && (ir == OP_TBLRD);
    wire op_interrupt_return_instr = ir_live && (ir[15:1] == OP_INTERRUPT_RETURN_INSTR);
    wire op_return = ir_live && (ir[15:1] == OP_RETURN);
    wire op_movlb = ir_live && (ir[15:4] == OP_MOVLB);
    wire op_add_working_to_file_instr = ir_live && (ir[15:10] == OP_ADD_WORKING_TO_FILE_INSTR);
    wire op_return_with_literal_instr = ir_live && (ir[15:8] == OP_RETURN_WITH_LITERAL_INSTR);
    wire op_movlw = ir_live && (ir[15:8] == OP_MOVLW);
    wire op_call = ir_live && (ir[15:9] == OP_CALL);
    wire op_goto = ir_live && (ir[15:8] == OP_GOTO);
    wire op_bra = ir_live && (ir[15:11] == OP_BRA);

    wire fast_ret = (op_interrupt_return_instr || op_return) && ir[0];
    wire fast_call = op_call && ir[8];

    // Operand fields of the add instruction
    wire add_dest_f = ir[9];
    wire add_a = ir[8];
    wire [7:0] add_f = ir[7:0];
    wire hits_pcl = !add_a && (add_f == PCL_FILE);
    wire [11:0] operand_addr = access_addr(add_a, add_f,
        bank_select_register);

    // Counter low is served here, not from data memory
    wire [20:0] next_instr = pc - PC_STEP;
    wire [7:0] addend = hits_pcl ? next_instr[7:0] : data_rdata;
    wire [7:0] add_sum = addend + working_register;
    wire [4:0] add_fl = add_flags(addend, working_register);

    // RULE_06 - computed jump on write
    wire pcl_jump = op_add_working_to_file_instr && hits_pcl && add_dest_f;
    wire two_word = op_call || op_goto;
    wire is_return = op_interrupt_return_instr || op_return || op_return_with_literal_instr;
    wire redirect = two_word || op_bra || pcl_jump || is_return;

    // Interrupts wait for instruction boundaries that keep flow
    wire take_irq = irq_req && !redirect;
    wire [20:0] vector = irq_high ? VEC_HIGH : VEC_LOW;

    // RULE_15 - absolute word address
    wire [20:0] abs_target = {prog_data[11:0], ir[7:0], 1'b0};
    // RULE_16 - words doubled to bytes
    wire [20:0] rel_target = bra_target(pc, ir[10:0]);
    // RULE_14 - low bit forced clear
    wire [20:0] pcl_target = {next_instr[20:8], result[7:1], 1'b0};

    wire [20:0] next_pc = two_word ? abs_target :
        op_bra ? rel_target :
        pcl_jump ? pcl_target :
        is_return ? ret_addr :
        take_irq ? vector : pc;

    // RULE_03 - fast interrupt return
    // RULE_05 - fast subroutine return
    // RULE_07 - literal to working
    wire [7:0] next_w = fast_ret ? shadow_w :
        (op_return_with_literal_instr || op_movlw) ? ir[7:0] :
        (op_add_working_to_file_instr && !add_dest_f) ? result : working_register;
    wire [4:0] next_status = fast_ret ? shadow_status :
        op_add_working_to_file_instr ? result_flags : status;
    wire [3:0] next_bsr = fast_ret ? shadow_bsr :
        op_movlb ? ir[3:0] : bank_select_register;

    // RULE_02 - interrupt saves shadow
    // RULE_04 - later interrupt overwrites
    // RULE_05 - fast call saves
    wire shadow_load = take_irq || fast_call;

    // RULE_10 - step in phase one
    // RULE_13 - fetch from even address
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pc <= PC_RESET;
            prog_addr <= PC_RESET;
        end else if (clk_en && phase_one) begin
            prog_addr <= pc;
            pc <= pc + PC_STEP;
        end else if (clk_en && phase_four) begin
            pc <= next_pc;
        end
    end

    // RULE_10 - latch in phase four
    // RULE_11 - redirect drops prefetched word
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ir <= OP_NOP;
            ir_valid <= 1'b0;
        end else if (clk_en && phase_four) begin
            ir <= prog_data;
            ir_valid <= !(redirect || take_irq);
        end
    end

    // Return address, one level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ret_addr <= PC_RESET;
        end else if (clk_en && phase_four) begin
            if (op_call) begin
                ret_addr <= pc;
            end else if (take_irq) begin
                ret_addr <= prog_addr;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            working_register <= W_RESET;
            status <= STATUS_RESET;
            bank_select_register <= BSR_RESET;
        end else if (clk_en && phase_four) begin
            working_register <= next_w;
            status <= next_status;
            bank_select_register <= next_bsr;
        end
    end

    // RULE_01 - hidden shadow store
    // RULE_18 - cleared at reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shadow_w <= SHADOW_W_RESET;
            shadow_status <= SHADOW_STATUS_RESET;
            shadow_bsr <= SHADOW_BSR_RESET;
        end else if (clk_en && phase_four && shadow_load) begin
            shadow_w <= next_w;
            shadow_status <= next_status;
            shadow_bsr <= next_bsr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_ack <= 1'b0;
        end else if (clk_en) begin
            irq_ack <= phase_four && take_irq;
        end
    end

    // RULE_12 - operand read strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_rd <= 1'b0;
            data_addr <= 12'h000;
        end else if (clk_en && phase_one) begin
            data_rd <= op_add_working_to_file_instr && !hits_pcl;
            data_addr <= operand_addr;
        end else if (clk_en) begin
            data_rd <= 1'b0;
        end
    end

    // Sum held so phase four sees a stable value
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            result <= 8'h00;
            result_flags <= STATUS_RESET;
        end else if (clk_en && phase_three) begin
            result <= add_sum;
            result_flags <= add_fl;
        end
    end

    // RULE_12 - destination write strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_wr <= 1'b0;
            data_wdata <= 8'h00;
        end else if (clk_en && phase_three) begin
            data_wr <= op_add_working_to_file_instr && add_dest_f && !hits_pcl;
            data_wdata <= add_sum;
        end else if (clk_en) begin
            data_wr <= 1'b0;
        end
    end

    // RULE_08 - one byte per read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            table_rd <= 1'b0;
            table_addr <= TPTR_RESET;
        end else if (clk_en && phase_one) begin
            table_rd <= op_tblrd;
            table_addr <= table_pointer;
        end else if (clk_en) begin
            table_rd <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            table_latch <= TLATCH_RESET;
        end else if (clk_en && phase_three && op_tblrd) begin
            table_latch <= table_data;
        end
    end

    // Software places the table pointer byte by byte
    wire wr_tp_low = reg_wr && (reg_addr == REG_TPTR_LOW);
    wire wr_tp_high = reg_wr && (reg_addr == REG_TPTR_HIGH);
    wire wr_tp_upper = reg_wr && (reg_addr == REG_TPTR_UPPER);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            table_pointer <= TPTR_RESET;
        end else if (clk_en) begin
            if (wr_tp_low) begin
                table_pointer[7:0] <= reg_wdata;
            end
            if (wr_tp_high) begin
                table_pointer[15:8] <= reg_wdata;
            end
            if (wr_tp_upper) begin
                table_pointer[20:16] <= reg_wdata[4:0];
            end
        end
    end

    // Shadow store deliberately has no read path
    logic [7:0] read_mux;
    always_comb begin
        case (reg_addr)
            REG_STATUS: read_mux = {3'h0, status};
            REG_WORKING: read_mux = working_register;
            REG_BANK: read_mux = {4'h0, bank_select_register};
            REG_TLATCH: read_mux = table_latch;
            REG_TPTR_LOW: read_mux = table_pointer[7:0];
            REG_TPTR_HIGH: read_mux = table_pointer[15:8];
            REG_TPTR_UPPER: read_mux = {3'h0, table_pointer[20:16]};
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? read_mux : 8'h00;
        end
    end

endmodule : ipfs_core

// ==== tb/ipfs_core_sva.sv ====
module ipfs_core_sva
    import ipfs_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Core outputs
    input wire logic [20:0] prog_addr,
    input wire logic table_rd,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic irq_ack,
    input ipfs_phase_t phase,
    // Interrupt request
    input wire logic irq_req,
    input wire logic irq_high
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_vectored;
        phase == PH_ONE && $past(irq_req);
    endsequence

    // Request level is held, so two cycles back still shows the choice
    sequence s_vector_fetch;
        prog_addr == ($past(irq_high, 2) ? VEC_HIGH : VEC_LOW);
    endsequence

    a_phase_rotate: assert property (
        clk_en && !reset |=> phase == {$past(phase[2:0]), $past(phase[3])})
        else $error("phase did not rotate");
    a_phase_freeze: assert property (
        !clk_en |=> $stable(phase) && $stable(prog_addr))
        else $error("state moved while clock enable low");
    a_fetch_phase: assert property (
        $changed(prog_addr) |-> phase == PH_TWO)
        else $error("fetch address changed outside phase two");
    a_addr_even: assert property (
        prog_addr[0] == 1'b0)
        else $error("odd fetch address");
    a_operand_read: assert property (
        data_rd |-> phase == PH_TWO ##1 !data_rd)
        else $error("operand read outside phase two");
    a_dest_write: assert property (
        data_wr |-> phase == PH_FOUR && $past(data_rd, 2))
        else $error("destination write not in phase four");
    a_table_once: assert property (
        table_rd |-> phase == PH_TWO ##1 !table_rd [*3])
        else $error("table read not a single phase two pulse");
    a_irq_vector: assert property (
        irq_ack |-> s_vectored ##1 s_vector_fetch)
        else $error("interrupt vectoring wrong");
    a_ack_single: assert property (
        irq_ack |=> !irq_ack [*3])
        else $error("interrupt acknowledge too long");
endmodule : ipfs_core_sva

// ==== tb/ipfs_mem_model.sv ====
module ipfs_mem_model (
    // Clock
    input wire logic sys_clk,
    // Program memory
    input wire logic [20:0] prog_addr,
    output logic [15:0] prog_data,
    input wire logic [20:0] table_addr,
    output logic [7:0] table_data,
    // Data memory
    input wire logic [11:0] data_addr,
    input wire logic data_rd,
    output logic [7:0] data_rdata,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rom [0:255];
    logic [7:0] ram [0:4095];
    logic [15:0] table_word;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            ram[i] = 8'h00;
        end
        data_rdata = 8'h00;
    end
    assign prog_data = rom[prog_addr[8:1]];
    assign table_word = rom[table_addr[8:1]];
    assign table_data = table_addr[0] ? table_word[15:8] : table_word[7:0];
    // Read data only valid the cycle after the strobe; toggles otherwise
    always @(posedge sys_clk) begin
        if (data_rd) begin
            data_rdata <= ram[data_addr];
        end else begin
            data_rdata <= ~data_rdata;
        end
        if (data_wr) begin
            ram[data_addr] <= data_wdata;
        end
    end
endmodule : ipfs_mem_model

// ==== tb/ipfs_core_tb.sv ====
module ipfs_core_tb
    import ipfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, clk_en, table_rd, data_rd, data_wr;
    logic irq_req, irq_high, irq_ack, reg_wr, reg_rd;
    logic [20:0] prog_addr, table_addr;
    logic [15:0] prog_data, tw;
    logic [11:0] data_addr;
    logic [7:0] table_data, data_rdata, data_wdata, reg_wdata, reg_rdata;
    logic [7:0] k1, k3;
    logic [7:0] lit [4];
    logic [3:0] b;
    logic [2:0] reg_addr;
    ipfs_phase_t phase;
    int err_total, cmp_count, j;

    ipfs_core DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .table_addr(table_addr), .table_rd(table_rd),
        .table_data(table_data), .data_addr(data_addr), .data_rd(data_rd),
        .data_rdata(data_rdata), .data_wr(data_wr), .data_wdata(data_wdata),
        .irq_req(irq_req), .irq_high(irq_high), .irq_ack(irq_ack),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase(phase));
    ipfs_mem_model MEM (.sys_clk(sys_clk), .prog_addr(prog_addr),
        .prog_data(prog_data), .table_addr(table_addr),
        .table_data(table_data), .data_addr(data_addr), .data_rd(data_rd),
        .data_rdata(data_rdata), .data_wr(data_wr), .data_wdata(data_wdata));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] tab_byte(input logic [15:0] w,
        input logic odd);
        return odd ? w[15:8] : w[7:0];
    endfunction : tab_byte

    // Status after an add, packed as the status offset reads it
    function automatic logic [7:0] exp_status(input logic [7:0] x,
        input logic [7:0] y);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, x} + {1'b0, y};
        h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
        return {3'h0, s[7], (x[7] == y[7]) && (s[7] != x[7]),
            s[7:0] == 8'h00, h[4], s[8]};
    endfunction : exp_status

    task automatic check(input logic [20:0] got, input logic [20:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask : reg_read

    // Holds the request until acknowledged, then drops it
    task automatic take_irq(input logic h);
        int n;
        @(posedge sys_clk);
        irq_high <= h;
        irq_req <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge sys_clk);
            #1;
            if (irq_ack === 1'b1) break;
        end
        if (n == 100) begin
            err_total++;
            results();
        end else begin
            @(posedge sys_clk);
            irq_req <= 1'b0;
        end
    endtask : take_irq

    initial begin
        {reset, clk_en, irq_req, irq_high, reg_wr, reg_rd} = 6'b11_0000;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        err_total = 0;
        cmp_count = 0;
        void'($urandom(32'h1bb2b559));
        k1 = 8'($urandom);
        k3 = 8'($urandom);
        b = 4'($urandom);
        j = int'($urandom % 4);
        tw = 16'($urandom);
        for (int i = 0; i < 256; i++) MEM.rom[i] = OP_NOP;
        for (int i = 0; i < 4; i++) lit[i] = 8'($urandom);
        for (int i = 0; i < 4; i++) MEM.rom[145 + i] = {8'h0C, lit[i]};
        {MEM.rom[0], MEM.rom[1]} = {16'hEF20, 16'hF000};
        {MEM.rom[4], MEM.rom[5], MEM.rom[6]} = {48'h0E77_2615_0011};
        {MEM.rom[12], MEM.rom[13], MEM.rom[14]} = {48'h0E33_2616_0011};
        {MEM.rom[32], MEM.rom[33]} = {8'h0E, k1, 12'h010, b};
        {MEM.rom[34], MEM.rom[35], MEM.rom[36]} = {48'hED80_F000_2610};
        MEM.rom[37] = {8'h0E, 8'(2 * j)};
        {MEM.rom[38], MEM.rom[39], MEM.rom[40]} = {48'hEC90_F000_2612};
        {MEM.rom[41], MEM.rom[42], MEM.rom[43]} = {48'h0008_D001_2613};
        {MEM.rom[44], MEM.rom[45]} = {32'hFFFF_2614};
        {MEM.rom[46], MEM.rom[47], MEM.rom[48]} = {8'h0E, k3, 32'h0000_D7FE};
        {MEM.rom[128], MEM.rom[129]} = {8'h0E, ~k1, 12'h010, ~b};
        {MEM.rom[130], MEM.rom[144], MEM.rom[160]} = {32'h0013_26F9, tw};
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        reg_write(REG_TPTR_LOW, 8'h41);
        reg_write(REG_TPTR_HIGH, 8'h01);
        reg_write(REG_TPTR_UPPER, 8'h00);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (300) @(posedge sys_clk);
        check(MEM.ram[12'h010], k1);
        check(MEM.ram[12'h012], lit[j]);
        check(MEM.ram[12'h013], 8'h00);
        check(MEM.ram[12'h014], lit[j]);
        reg_read(REG_TLATCH, tab_byte(tw, 1'b1));
        reg_read(REG_BANK, {4'h0, b});
        reg_read(3'h7, 8'h00);
        take_irq(1'b1);
        repeat (40) @(posedge sys_clk);
        check(MEM.ram[12'h015], 8'h77);
        reg_read(REG_WORKING, k3);
        reg_read(REG_STATUS, exp_status(8'h00, lit[j]));
        // High request lands while the low handler runs
        take_irq(1'b0);
        repeat (6) @(posedge sys_clk);
        take_irq(1'b1);
        repeat (60) @(posedge sys_clk);
        check(MEM.ram[12'h016], 8'h33);
        reg_read(REG_WORKING, 8'h33);
        reg_read(REG_BANK, {4'h0, b});
        reg_read(REG_STATUS, exp_status(8'h00, 8'h33));
        check(MEM.ram[12'h015], 8'hEE);
        results();
    end
endmodule : ipfs_core_tb

bind ipfs_core ipfs_core_sva u_sva (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .prog_addr(prog_addr), .table_rd(table_rd),
    .data_rd(data_rd), .data_wr(data_wr), .irq_ack(irq_ack),
    .phase(phase), .irq_req(irq_req), .irq_high(irq_high));
